// [rtl/scdc_controller.sv]
// Operation
// - Initial access three cycles, bursts single-cycle
// - Five-cycle refresh every 15.6 microseconds
// - Refresh interval counts 390 clock cycles
// - Refresh ends burst; processor re-sends address
// - Idle refresh adds no later delay
// - Row change inserts two-cycle precharge
// - Access ended earlier means no precharge
// - Access still open delays by precharge
// - Burst lasts until next request address
// - Instruction side assumes pending burst for requests taken with reqBurst set
// - Idle cycle doubles as precharge and decode
// - Other-block request ends suspended instruction burst
// - Data side ends access when request drops
// - Same-row request skips to column access
// - Refresh preemption bounds row strobe width
`timescale 1ns/10ps
`default_nettype none
module scdc_controller
    import scdc_pkg::*;
#(
    parameter bit DataSide = 1'b0,
    parameter bit RowCompare = 1'b1
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Processor request
    input wire logic reqValid,
    input wire logic reqOwnBlock,
    input wire logic [AddrWidth-1:0] reqAddr,
    input wire logic reqBurst,
    input wire logic data_burst_request,
    output logic reqAccept,
    // Read data toward processor
    output logic rdValid,
    input wire logic rdReady,
    output logic [DataWidth-1:0] rdData,
    // Memory array
    output logic rowStrobeN,
    output logic colStrobeN,
    output logic [ColWidth-1:0] memCol,
    output logic [RowWidth-1:0] memRow,
    input wire logic [DataWidth-1:0] memData
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    scdc_state_t state_q;
    logic [2:0] cnt_q;
    logic [RowWidth-1:0] row_q;
    logic [ColWidth-1:0] col_q;
    logic rowOpen_q;
    logic burstLive_q;
    logic wordValid_q;
    logic [DataWidth-1:0] word_q;
    logic refreshDue;
    logic refreshDone;
    logic fifoReady;
    logic newReq;
    logic rowHit;
    logic otherBlock;
    logic startNew;
    logic canTake;
    logic capture;

    scdc_stream_if wordStream ();

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    scdc_refresh_timer uTimer (
        .clk(clk),
        .rst(rst),
        .refreshDone(refreshDone),
        .refreshDue(refreshDue)
    );

    scdc_fifo #(.Width(DataWidth), .Depth(FifoDepth)) uFifo (
        .clk(clk),
        .rst(rst),
        .inValid(wordStream.valid),
        .inReady(wordStream.ready),
        .inData(wordStream.data),
        .outValid(rdValid),
        .outReady(rdReady),
        .outData(rdData)
    );

    assign wordStream.valid = wordValid_q;
    assign wordStream.data = word_q;
    assign fifoReady = wordStream.ready;

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    assign newReq = reqValid && reqOwnBlock;
    assign otherBlock = reqValid && !reqOwnBlock;
    assign rowHit = RowCompare && rowOpen_q && (reqAddr[AddrWidth-1:ColWidth] == row_q);
    // Refresh first, then a new own request; a full FIFO stalls starts
    assign startNew = newReq && !refreshDue && fifoReady;
    assign refreshDone = (state_q == ScRefresh) && (cnt_q == 3'h0);

    // ------------------------------------------------------------
    // Control state machine
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= ScIdle;
            cnt_q <= 3'h0;
        end
        else
        begin
            case (state_q)
                ScIdle:
                begin
                    // Idle is already one precharge/decode cycle
                    if (refreshDue)
                    begin
                        state_q <= ScRefresh;
                        cnt_q <= RefreshLen - 3'h2;
                    end
                    else if (startNew)
                    begin
                        state_q <= ScInitial;
                        cnt_q <= {1'b0, InitialWaits} - 3'h2;
                    end
                end
                ScPrecharge:
                begin
                    if (cnt_q == 3'h0)
                    begin
                        state_q <= ScIdle;
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 3'h1;
                    end
                end
                ScInitial:
                begin
                    if (cnt_q == 3'h0)
                    begin
                        state_q <= ScBurst;
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 3'h1;
                    end
                end
                ScBurst:
                begin
                    if (refreshDue)
                    begin
                        state_q <= ScPrecharge;
                        cnt_q <= {1'b0, PrechargeLen} - 3'h2;
                    end
                    else if (startNew && rowHit)
                    begin
                        state_q <= ScInitial;
                        cnt_q <= {1'b0, RowHitWaits} - 3'h2;
                    end
                    else if (newReq || otherBlock)
                    begin
                        state_q <= ScPrecharge;
                        cnt_q <= {1'b0, PrechargeLen} - 3'h2;
                    end
                    else if (DataSide && !data_burst_request)
                    begin
                        state_q <= ScPrecharge;
                        cnt_q <= {1'b0, PrechargeLen} - 3'h2;
                    end
                end
                ScRefresh:
                begin
                    if (cnt_q == 3'h0)
                    begin
                        state_q <= ScIdle;
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 3'h1;
                    end
                end
                default:
                begin
                    state_q <= ScIdle;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Address latch and open row
    // ------------------------------------------------------------
    assign reqAccept = (state_q == ScIdle && !refreshDue && startNew) ||
        (state_q == ScBurst && !refreshDue && startNew && rowHit);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            row_q <= '0;
            col_q <= '0;
            rowOpen_q <= 1'b0;
            burstLive_q <= 1'b0;
        end
        else
        begin
            if (reqAccept)
            begin
                row_q <= reqAddr[AddrWidth-1:ColWidth];
                col_q <= reqAddr[ColWidth-1:0];
                burstLive_q <= reqBurst;
            end
            else if (capture)
            begin
                col_q <= col_q + 1'b1;
            end
            if (state_q == ScInitial)
            begin
                rowOpen_q <= 1'b1;
            end
            else if (state_q != ScBurst)
            begin
                rowOpen_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Word capture into FIFO
    // ------------------------------------------------------------
    // First word at end of initial, then one per cycle while the slot is free
    assign canTake = !wordValid_q || fifoReady;
    assign capture = ((state_q == ScInitial && cnt_q == 3'h0) ||
        (state_q == ScBurst && burstLive_q && !refreshDue && !newReq && !otherBlock &&
        !(DataSide && !data_burst_request))) && canTake;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wordValid_q <= 1'b0;
            word_q <= '0;
        end
        else
        begin
            // Held word waits for the buffer, so none is lost when it fills
            if (capture)
            begin
                wordValid_q <= 1'b1;
                word_q <= memData;
            end
            else if (fifoReady)
            begin
                wordValid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Array strobes
    // ------------------------------------------------------------
    assign rowStrobeN = !(state_q == ScInitial || state_q == ScBurst || state_q == ScRefresh);
    assign colStrobeN = !(state_q == ScBurst || (state_q == ScInitial && cnt_q == 3'h0));
    assign memRow = row_q;
    assign memCol = col_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_initial_three_waits:
    assert property (@(posedge clk) disable iff (rst)
        (state_q == ScIdle && startNew && !refreshDue) |=> state_q == ScInitial ##1
        state_q == ScInitial ##1 state_q == ScBurst)
    else $error("initial access length wrong");

    chk_refresh_five:
    assert property (@(posedge clk) disable iff (rst)
        (state_q == ScIdle && refreshDue) |=> (state_q == ScRefresh) [*4] ##1 state_q == ScIdle)
    else $error("refresh sequence length wrong");

    chk_preempt_burst:
    assert property (@(posedge clk) disable iff (rst)
        (state_q == ScBurst && refreshDue) |=> state_q == ScPrecharge && !reqAccept)
    else $error("refresh did not end burst");

    chk_precharge_two:
    assert property (@(posedge clk) disable iff (rst)
        $rose(state_q == ScPrecharge) |=> state_q == ScIdle)
    else $error("precharge length wrong");

    chk_data_end:
    assert property (@(posedge clk) disable iff (rst)
        (DataSide && state_q == ScBurst && !data_burst_request && !refreshDue)
        |=> state_q != ScBurst)
    else $error("data access not ended");

    chk_other_block:
    assert property (@(posedge clk) disable iff (rst)
        (state_q == ScBurst && otherBlock && !newReq) |=> state_q == ScPrecharge)
    else $error("other block request did not end burst");

    chk_row_hit:
    assert property (@(posedge clk) disable iff (rst)
        (state_q == ScBurst && reqAccept) |=> state_q == ScInitial ##1 state_q == ScBurst)
    else $error("row hit access length wrong");

    chk_refresh_priority:
    assert property (@(posedge clk) disable iff (rst)
        (state_q == ScIdle && refreshDue) |-> !reqAccept ##1 state_q == ScRefresh)
    else $error("access started ahead of refresh");

    chk_row_closed:
    assert property (@(posedge clk) disable iff (rst)
        (state_q == ScRefresh) |-> !rowOpen_q || $past(state_q) == ScIdle)
    else $error("row left open into refresh");
endmodule // scdc_controller
`default_nettype wire

// [rtl/scdc_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module scdc_fifo
    import scdc_pkg::*;
#(
    parameter int Width = 32,
    parameter int Depth = 16
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [Width-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [Width-1:0] outData
);
    localparam int Aw = $clog2(Depth);
    logic [Width-1:0] mem [Depth];
    logic [Aw:0] wrPtr_q;
    logic [Aw:0] rdPtr_q;
    logic full;
    logic empty;

    assign empty = wrPtr_q == rdPtr_q;
    assign full = (wrPtr_q[Aw] != rdPtr_q[Aw]) && (wrPtr_q[Aw-1:0] == rdPtr_q[Aw-1:0]);
    assign inReady = !full;
    assign outValid = !empty;
    assign outData = mem[rdPtr_q[Aw-1:0]];

    always_ff @(posedge clk)
    begin
        if (inValid && !full)
        begin
            mem[wrPtr_q[Aw-1:0]] <= inData;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end
        else
        begin
            if (inValid && !full)
            begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (outReady && !empty)
            begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
        end
    end
endmodule // scdc_fifo
`default_nettype wire

// [rtl/scdc_pkg.sv]
package scdc_pkg;
    // Clock and refresh timing
    localparam int ClkPeriodNs = 40;
    localparam int RefreshIntervalNs = 15600;
    localparam int RefreshCycles = RefreshIntervalNs / ClkPeriodNs;
    localparam logic [8:0] RefreshCount = 9'(RefreshCycles - 1);
    localparam logic [2:0] RefreshLen = 3'h5;
    localparam logic [1:0] PrechargeLen = 2'h2;
    localparam logic [1:0] InitialWaits = 2'h3;
    localparam logic [1:0] RowHitWaits = 2'h2;
    // Address layout
    localparam int AddrWidth = 22;
    localparam int ColWidth = 10;
    localparam int RowWidth = AddrWidth - ColWidth;
    localparam int DataWidth = 32;
    localparam int FifoDepth = 16;

    typedef enum logic [2:0] {
        ScIdle = 3'b000,
        ScPrecharge = 3'b001,
        ScInitial = 3'b010,
        ScBurst = 3'b011,
        ScRefresh = 3'b100
    } scdc_state_t;
endpackage

// [rtl/scdc_refresh_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module scdc_refresh_timer
    import scdc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Refresh request handshake
    input wire logic refreshDone,
    output logic refreshDue
);
    logic [8:0] count_q;
    logic due_q;

    // Interval counter, one tick per expiry
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            count_q <= RefreshCount;
        end
        else if (count_q == 9'h000)
        begin
            count_q <= RefreshCount;
        end
        else
        begin
            count_q <= count_q - 9'h001;
        end
    end

    // Pending flag, expiry wins over the clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            due_q <= 1'b0;
        end
        else if (count_q == 9'h000)
        begin
            due_q <= 1'b1;
        end
        else if (refreshDone)
        begin
            due_q <= 1'b0;
        end
    end

    assign refreshDue = due_q;

    chk_refresh_period:
    assert property (@(posedge clk) disable iff (rst)
        (count_q == 9'h000) |=> due_q && count_q == RefreshCount)
    else $error("refresh not requested at interval expiry");
endmodule // scdc_refresh_timer
`default_nettype wire

// [rtl/scdc_stream_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface scdc_stream_if;
    import scdc_pkg::*;
    logic valid;
    logic ready;
    logic [DataWidth-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface // scdc_stream_if
`default_nettype wire

// [testbench/scdc_array_model.sv]
`timescale 1ns/10ps
`default_nettype none
module scdc_array_model
    import scdc_pkg::*;
(
    // Clock
    input wire logic clk,
    // Array strobes and address
    input wire logic rowStrobeN,
    input wire logic colStrobeN,
    input wire logic [RowWidth-1:0] memRow,
    input wire logic [ColWidth-1:0] memCol,
    // Read data
    output logic [DataWidth-1:0] memData
);
    logic [DataWidth-1:0] junk_q = 32'h5a5a0f0f;

    // Unselected array shows a changing pattern, never stale data
    always_ff @(posedge clk)
    begin
        junk_q <= ~junk_q + 32'h1;
    end

    // Word content encodes its own row and column
    assign memData = (!rowStrobeN && !colStrobeN) ? {memRow, memCol, memCol} : junk_q;
endmodule // scdc_array_model
`default_nettype wire

// [testbench/static_column_dram_controller_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module static_column_dram_controller_bench;
    import scdc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reqValid = 1'b0;
    logic reqOwnBlock = 1'b1;
    logic [AddrWidth-1:0] reqAddr = '0;
    logic reqBurst = 1'b1;
    logic dataBurstReq = 1'b1;
    logic rdReady = 1'b1;
    logic reqAccept, rdValid, rowStrobeN, colStrobeN;
    logic [DataWidth-1:0] rdData, memData;
    logic [ColWidth-1:0] memCol;
    logic [RowWidth-1:0] memRow;
    logic [AddrWidth-1:0] lastAddr = '0;
    logic [AddrWidth-1:0] pending[$];
    logic havePrev = 1'b0;
    int fails = 0;
    int comparisons = 0;
    int cyc = 0;
    int waitCnt, lat, n, target;

    scdc_controller #(.DataSide(1'b0), .RowCompare(1'b1)) scdc_controller_i (
        .clk(clk), .rst(rst), .reqValid(reqValid), .reqOwnBlock(reqOwnBlock),
        .reqAddr(reqAddr), .reqBurst(reqBurst), .data_burst_request(dataBurstReq),
        .reqAccept(reqAccept), .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData),
        .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .memCol(memCol),
        .memRow(memRow), .memData(memData));

    scdc_array_model scdc_array_model_i (
        .clk(clk), .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
        .memRow(memRow), .memCol(memCol), .memData(memData));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [DataWidth-1:0] expWord(input logic [AddrWidth-1:0] a);
        return {a[AddrWidth-1:ColWidth], a[ColWidth-1:0], a[ColWidth-1:0]};
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Present a request at a falling edge; hold an own-block one until taken
    task automatic request(input logic [AddrWidth-1:0] a, input logic own);
        reqAddr = a;
        reqOwnBlock = own;
        reqBurst = 1'b1;
        reqValid = 1'b1;
        waitCnt = 0;
        #1;
        while (own && reqAccept !== 1'b1 && waitCnt < 50)
        begin
            @(negedge clk);
            waitCnt++;
            #1;
        end
        if (own)
            pending.push_back(a);
        @(negedge clk);
        reqValid = 1'b0;
        reqOwnBlock = 1'b1;
    endtask

    // Cycles from the accepting edge until the array column strobe reads the word
    task automatic first_word(input string what, input logic [AddrWidth-1:0] a);
        lat = 1;
        while (!(colStrobeN === 1'b0 && rowStrobeN === 1'b0 && {memRow, memCol} === a)
            && lat < 20)
        begin
            @(negedge clk);
            lat++;
        end
        check(what, 32'(InitialWaits) - 32'h1, 32'(lat));
    endtask

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Clock, watchdog, read-data monitor
    // ----------------------------------------
    initial
    begin
        forever #2 clk = ~clk;
    end

    initial
    begin
        #40000;
        fails++;
        give_verdict();
    end

    // Each word is the next column or the start of a newly taken request
    always @(posedge clk)
    begin
        if (!rst)
            cyc++;
        if (rdValid === 1'b1 && rdReady === 1'b1)
        begin
            comparisons++;
            if (havePrev && rdData === expWord(lastAddr + 22'h1))
                lastAddr = lastAddr + 22'h1;
            else if (pending.size() > 0 && rdData === expWord(pending[0]))
            begin
                lastAddr = pending.pop_front();
                havePrev = 1'b1;
            end
            else
            begin
                fails++;
                $display("CHECK FAILED rdData expected %h seen %h",
                    expWord(lastAddr + 22'h1), rdData);
            end
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'h1178));
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("outputs in reset", 32'hc, {28'h0, rowStrobeN, colStrobeN, rdValid, reqAccept});
        rst = 1'b0;
        request({12'h0a5, 10'h000}, 1'b1);
        check("wait from idle", 32'h0, 32'(waitCnt));
        first_word("initial latency", {12'h0a5, 10'h000});
        @(negedge clk);
        check("first word held", 32'h0, 32'(rdValid));
        @(negedge clk);
        check("first word out", 32'h1, 32'(rdValid));
        n = 0;
        repeat (8)
        begin
            @(negedge clk);
            n += (rdValid === 1'b1) ? 1 : 0;
        end
        check("single-cycle burst", 32'h8, 32'(n));
        n = 0;
        while (rdValid === 1'b1 && n < 600)
        begin
            @(negedge clk);
            n++;
        end
        check("refresh interval", 32'h1,
            32'(cyc >= RefreshCycles - 2 && cyc <= RefreshCycles + 6));
        request({12'h0a5, 10'h200}, 1'b1);
        check("resend after refresh", 32'h1,
            32'(waitCnt <= 32'(RefreshLen) + 32'(PrechargeLen)));
        first_word("latency after refresh", {12'h0a5, 10'h200});
        rdReady = 1'b0;
        repeat (24) @(negedge clk);
        check("full buffer holds", 32'h1, 32'(rdValid));
        repeat (40)
        begin
            rdReady = 1'($urandom);
            @(negedge clk);
        end
        rdReady = 1'b1;
        request({12'h13c, 10'h010}, 1'b1);
        check("precharge hold-off", 32'h1,
            32'(waitCnt >= 1 && waitCnt <= 32'(PrechargeLen)));
        first_word("latency after precharge", {12'h13c, 10'h010});
        repeat (6) @(negedge clk);
        request({12'h7ff, 10'h000}, 1'b0);
        repeat (4) @(negedge clk);
        request({12'h2f1, 10'h020}, 1'b1);
        check("precharge already met", 32'h0, 32'(waitCnt));
        first_word("latency after other block", {12'h2f1, 10'h020});
        repeat (5) @(negedge clk);
        request({12'h2f1, 10'h300}, 1'b1);
        check("same-row wait", 32'h0, 32'(waitCnt));
        repeat (8) @(negedge clk);
        repeat (6)
        begin
            request({12'($urandom), 1'b0, 9'($urandom)}, 1'b1);
            check("random taken", 32'h1, 32'(waitCnt < 50));
            repeat (3 + $urandom % 12)
            begin
                rdReady = 1'($urandom);
                @(negedge clk);
            end
            rdReady = 1'b1;
        end
        request({12'h7ff, 10'h000}, 1'b0);
        target = ((cyc / RefreshCycles) + 1) * RefreshCycles + 20;
        while (cyc < target)
            @(negedge clk);
        request({12'h055, 10'h040}, 1'b1);
        check("idle refresh free", 32'h0, 32'(waitCnt));
        first_word("latency after idle refresh", {12'h055, 10'h040});
        repeat (10) @(negedge clk);
        give_verdict();
    end
endmodule // static_column_dram_controller_bench
`default_nettype wire
